/* cascaded_word_timer.sv */
// Cascaded 16-bit down timer: low_byte_timer and high_byte_timer form
// one cascaded_word_timer with its registers on an APB slave port.
// Assumes pclk is the crystal clock and all inputs are on pclk.
//
// What this block does
// - Two byte timers run only as one word
// - Each byte timer: readable/writable count and reload
// - Enabled timer decrements to zero, then interrupts
// - Without reload, stop at zero, clear enable
// - With reload, resume from reload value
// - Software count write continues from new value
// - Reload write used at next zero
// - Software write beats decrement writeback
// - Hardware enable clear beats control write
// - Reads never disturb counting or interrupts
// - One interrupt when whole word reaches zero
// - Interrupt appears on the low-byte timer line
// - Low timer holds LSB, high timer MSB
// - Reload copy happens with interrupt posting
// - Reload free-running while interrupt pending
// - No overrun detection of repeated zero
// - Enabling starts from present count, no reload
// - Internal clock only, step every eighth cycle
// - Hardware reset leaves timers disabled
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps

module cascaded_word_timer
  import timer16_pkg::*;
(
  // Clock, reset and freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt request of the low-byte timer
  output logic low_byte_timer_irq
);

  // Address match for one register word
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Register map, one byte per aligned word, upper data bits read as zero:
  //   control       bit 0 enable, bit 1 reload enable, resets to reload on
  //   low count     byte 7:0 of the running word
  //   low reload    byte 7:0 of the value copied in at zero
  //   high count    byte 15:8 of the running word
  //   high reload   byte 15:8 of the value copied in at zero
  // Anything else answers with an error and is otherwise ignored.
  //
  // Timing, counted in enabled clocks after the write that sets enable:
  //   the prescaler starts from zero, so the first step is eight clocks on
  //   each step lowers the whole word by one, with the borrow between bytes
  //   the step that starts from one (or finds zero) is the zero event
  //   the interrupt pulse follows the zero event by one clock
  //
  // Limitations a user must know:
  //   software writes each byte alone, so a running word can be caught
  //   half written; stop the timer first when both bytes must change
  //   a second zero before the first is serviced is not flagged
  //   a low clock enable freezes everything and holds the bus in access
  //
  // Timer state; bit 7:0 is the low-byte timer, 15:8 the high-byte timer
  logic [15:0] count;
  logic [15:0] reload;
  logic ctl_enable;
  logic ctl_reload;
  logic [2:0] presc;
  logic [15:0] next_count;
  logic [15:0] hw_count;

  // Register decode
  wire sel_ctl = hit(paddr, OFS_TIMER_CONTROL);
  wire sel_cnt_lo = hit(paddr, OFS_LOW_COUNT);
  wire sel_rld_lo = hit(paddr, OFS_LOW_RELOAD);
  wire sel_cnt_hi = hit(paddr, OFS_HIGH_COUNT);
  wire sel_rld_hi = hit(paddr, OFS_HIGH_RELOAD);
  wire mapped = sel_ctl | sel_cnt_lo | sel_rld_lo | sel_cnt_hi | sel_rld_hi;

  // Writes land only in the access phase, and never while frozen
  wire wr_access = psel & penable & pwrite & clk_en;
  wire wr_ctl = wr_access & sel_ctl;
  wire wr_cnt_lo = wr_access & sel_cnt_lo;
  wire wr_cnt_hi = wr_access & sel_cnt_hi;
  wire wr_rld_lo = wr_access & sel_rld_lo;
  wire wr_rld_hi = wr_access & sel_rld_hi;
  wire setup_phase = psel & ~penable & clk_en;

  // Step strobe: every eighth enabled crystal clock
  wire tick = clk_en & ctl_enable & (presc == TICK_LAST);

  // The whole word reaches zero on this step; 0 counts as already there
  wire zero_hit = tick & (count <= COUNT_ONE);
  wire oneshot_end = zero_hit & ~ctl_reload;

  // Zero-wait slave; stalls while the block is frozen
  assign pready = clk_en;

  // Read view; a read has no side effect anywhere
  wire [31:0] rd_view = sel_ctl ? {30'h0000_0000, ctl_reload, ctl_enable} :
                        sel_cnt_lo ? {24'h00_0000, count[7:0]} :
                        sel_cnt_hi ? {24'h00_0000, count[15:8]} :
                        sel_rld_lo ? {24'h00_0000, reload[7:0]} :
                        sel_rld_hi ? {24'h00_0000, reload[15:8]} :
                        32'h0000_0000;

  // Hardware value: reload copy goes with the interrupt, else decrement
  always_comb begin
    if (zero_hit) begin
      hw_count = ctl_reload ? reload : COUNT_RESET;
    end else if (tick) begin
      hw_count = count - COUNT_ONE;
    end else begin
      hw_count = count;
    end
  end

  // Software byte writes override the hardware writeback byte by byte
  always_comb begin
    next_count = hw_count;
    if (wr_cnt_lo) begin
      next_count[7:0] = pwdata[7:0];
    end
    if (wr_cnt_hi) begin
      next_count[15:8] = pwdata[7:0];
    end
  end

  // Count register, one word across both byte timers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= COUNT_RESET;
    end else if (clk_en) begin
      count <= next_count;
    end
  end

  // Reload registers; the value in place at zero is the one used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload <= RELOAD_RESET;
    end else begin
      if (wr_rld_lo) begin
        reload[7:0] <= pwdata[7:0];
      end
      if (wr_rld_hi) begin
        reload[15:8] <= pwdata[7:0];
      end
    end
  end

  // Enable bit: the one-shot clear overrides a simultaneous write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_enable <= CTL_RESET[CTL_ENABLE_POS];
    end else if (oneshot_end) begin
      ctl_enable <= 1'b0;
    end else if (wr_ctl) begin
      ctl_enable <= pwdata[CTL_ENABLE_POS];
    end
  end

  // Reload mode bit, software only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reload <= CTL_RESET[CTL_RELOAD_POS];
    end else if (wr_ctl) begin
      ctl_reload <= pwdata[CTL_RELOAD_POS];
    end
  end

  // Prescaler restarts whenever the timer is stopped, so the first
  // step after enabling comes a full eight clocks later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= 3'h0;
    end else if (clk_en) begin
      presc <= ctl_enable ? presc + 3'h1 : 3'h0;
    end
  end

  // Interrupt pulse; a second zero before service is not flagged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_byte_timer_irq <= 1'b0;
    end else if (clk_en) begin
      low_byte_timer_irq <= zero_hit;
    end
  end

  // Read data and error are captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_view;
      pslverr <= ~mapped;
    end
  end

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire no_cnt_wr = !wr_cnt_lo && !wr_cnt_hi;

  sequence quiet_seven;
    !tick [*7];
  endsequence

  sequence step_then_quiet;
    tick ##1 quiet_seven;
  endsequence

  irq_pulse_a: assert property (low_byte_timer_irq && clk_en |=> !low_byte_timer_irq)
    else $error("interrupt longer than one cycle");

  // A pulse held over a freeze no longer sees the count of its zero event
  irq_cause_a: assert property (low_byte_timer_irq && $past(clk_en) |-> $past(count) <= COUNT_ONE)
    else $error("interrupt without word reaching zero");

  reload_copy_a: assert property (zero_hit && ctl_reload && no_cnt_wr
    |=> count == $past(reload) && low_byte_timer_irq)
    else $error("reload not copied with interrupt");

  oneshot_stop_a: assert property (oneshot_end && no_cnt_wr
    |=> !ctl_enable && count == COUNT_RESET)
    else $error("single-shot did not stop at zero");

  clear_wins_a: assert property (oneshot_end && wr_ctl |=> !ctl_enable)
    else $error("control write beat hardware clear");

  decrement_step_a: assert property (tick && !zero_hit && no_cnt_wr
    |=> count == $past(count) - COUNT_ONE)
    else $error("count did not decrement");

  sw_write_wins_a: assert property (wr_cnt_lo && tick |=> count[7:0] == $past(pwdata[7:0]))
    else $error("decrement beat software write");

  tick_spacing_a: assert property (step_then_quiet or !tick)
    else $error("steps closer than eight clocks");

  read_quiet_a: assert property (psel && !pwrite
    |=> reload == $past(reload) && ctl_reload == $past(ctl_reload))
    else $error("read disturbed timer state");

  start_no_reload_a: assert property (wr_ctl && pwdata[CTL_ENABLE_POS] && !ctl_enable
    && no_cnt_wr |=> count == $past(count) && ctl_enable)
    else $error("enable did not start from count");

  freeze_hold_a: assert property (!clk_en |=> count == $past(count) && reload == $past(reload))
    else $error("count or reload moved while frozen");

  freeze_ctl_a: assert property (!clk_en
    |=> ctl_enable == $past(ctl_enable) && ctl_reload == $past(ctl_reload))
    else $error("control moved while frozen");

  freeze_presc_a: assert property (!clk_en |=> presc == $past(presc))
    else $error("prescaler moved while frozen");

  ready_follow_a: assert property (pready == clk_en)
    else $error("ready does not follow clock enable");

  idle_no_tick_a: assert property (!ctl_enable |-> !tick)
    else $error("step while disabled");

  disabled_hold_a: assert property (!ctl_enable && clk_en && no_cnt_wr |=> count == $past(count))
    else $error("disabled word changed");

  presc_clear_a: assert property (!ctl_enable && clk_en |=> presc == 3'h0)
    else $error("prescaler not cleared while disabled");

  presc_step_a: assert property (ctl_enable && clk_en |=> presc == $past(presc) + 3'h1)
    else $error("prescaler did not advance");

  zero_needs_en_a: assert property (zero_hit |-> ctl_enable)
    else $error("zero event while disabled");

  reload_hold_a: assert property (!wr_rld_lo && !wr_rld_hi |=> reload == $past(reload))
    else $error("reload changed without a write");

  rld_lo_write_a: assert property (wr_rld_lo |=> reload[7:0] == $past(pwdata[7:0]))
    else $error("low reload write lost");

  rld_hi_write_a: assert property (wr_rld_hi |=> reload[15:8] == $past(pwdata[7:0]))
    else $error("high reload write lost");

  cnt_lo_write_a: assert property (wr_cnt_lo |=> count[7:0] == $past(pwdata[7:0]))
    else $error("low count write lost");

  cnt_hi_write_a: assert property (wr_cnt_hi |=> count[15:8] == $past(pwdata[7:0]))
    else $error("high count write lost");

  ctl_write_a: assert property (wr_ctl && !oneshot_end
    |=> ctl_enable == $past(pwdata[CTL_ENABLE_POS]))
    else $error("enable write lost");

  reload_bit_a: assert property (wr_ctl |=> ctl_reload == $past(pwdata[CTL_RELOAD_POS]))
    else $error("reload mode write lost");

  no_irq_idle_a: assert property (!zero_hit && clk_en |=> !low_byte_timer_irq)
    else $error("interrupt without zero event");

  irq_follows_a: assert property (zero_hit |=> low_byte_timer_irq)
    else $error("zero event without interrupt");

  err_unmapped_a: assert property (setup_phase && !mapped |=> pslverr)
    else $error("unmapped access without error");

  rdata_hold_a: assert property (!setup_phase
    |=> prdata == $past(prdata) && pslverr == $past(pslverr))
    else $error("read data changed outside setup");

  free_run_a: assert property (zero_hit && ctl_reload |=> ctl_enable)
    else $error("reload mode stopped at zero");

  byte_borrow_a: assert property (tick && !zero_hit && count[7:0] == 8'h00 && no_cnt_wr
    |=> count[7:0] == 8'hff)
    else $error("low byte did not borrow");

  high_zero_a: assert property (low_byte_timer_irq && $past(clk_en)
    |-> $past(count[15:8]) == 8'h00)
    else $error("interrupt with high byte set");

  read_no_count_a: assert property (psel && !pwrite && tick && !zero_hit
    |=> count == $past(count) - COUNT_ONE)
    else $error("read disturbed the count");

endmodule

/* test_cascaded_word_timer.sv */
// Self-checking testbench for the cascaded 16-bit down timer.
// Assumes the timer package and the timer module are compiled first.
`timescale 1ns/10ps
module test_cascaded_word_timer
  import timer16_pkg::*;
;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] w, r, r2, m;
  logic [7:0] b;
  int n_mismatch, num_checks, n;
  logic [7:0] regs [5] = '{OFS_TIMER_CONTROL, OFS_LOW_COUNT, OFS_LOW_RELOAD,
                           OFS_HIGH_COUNT, OFS_HIGH_RELOAD};

  cascaded_word_timer u_cascaded_word_timer (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_byte_timer_irq(irq));

  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Edges from a start edge until the interrupt is seen: one step per eighth clock
  function automatic int ticks(input logic [15:0] v);
    return TICK_DIVIDE * int'(v) + 1;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict;
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One APB transfer; the idle edge first keeps back-to-back calls from double-driving psel
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Low byte at the given place, high byte eight bytes above it
  task automatic set_word(input logic [7:0] a, input logic [15:0] v);
    apb(1'b1, a, {24'($urandom), v[7:0]});
    apb(1'b1, a + 8'h08, {24'h00_0000, v[15:8]});
  endtask

  // Sampled on the falling edge, where the registered pulse has settled
  task automatic wait_irq(output int cnt);
    cnt = 0;
    do begin
      @(negedge pclk);
      cnt++;
    end while (irq !== 1'b1 && cnt < 5000);
    @(negedge pclk);
    chk("irq pulse width", 32'h0, {31'h0, irq});
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    give_verdict;
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    clk_en = 1'b1;
    n_mismatch = 0;
    num_checks = 0;
    void'($urandom(32'h99332b94));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, regs[i], 32'h0);
      chk("reset value", (i == 0) ? 32'(CTL_RESET) : 32'h0, q);
    end
    // Upper data bits are random to show they are dropped
    for (int i = 1; i < 5; i++) begin
      b = 8'($urandom);
      apb(1'b1, regs[i], {24'($urandom), b});
      apb(1'b0, regs[i], 32'h0);
      chk("register readback", {24'h00_0000, b}, q);
    end
    chk("mapped error", 32'h0, {31'h0, pslverr});
    apb(1'b0, 8'hd4, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, pslverr});
    // Single shot; reload differs from count so a reload at enable would show
    w = 16'($urandom_range(400, 2));
    r = 16'($urandom_range(50, 2));
    apb(1'b1, OFS_TIMER_CONTROL, 32'h0);
    set_word(OFS_LOW_COUNT, w);
    set_word(OFS_LOW_RELOAD, r);
    apb(1'b1, OFS_TIMER_CONTROL, 32'h0000_0001);
    wait_irq(n);
    chk("single shot ticks", ticks(w), n);
    apb(1'b0, OFS_TIMER_CONTROL, 32'h0);
    chk("single shot control", 32'h0, q);
    apb(1'b0, OFS_LOW_COUNT, 32'h0);
    chk("single shot count", 32'h0, q);
    // Free-running reload with reads in flight
    set_word(OFS_LOW_COUNT, w);
    apb(1'b1, OFS_TIMER_CONTROL, 32'h0000_0003);
    wait_irq(n);
    chk("reload first ticks", ticks(w), n);
    fork
      wait_irq(n);
      repeat (3) apb(1'b0, OFS_HIGH_COUNT, 32'h0);
    join
    chk("reload period", ticks(r) - 2, n);
    r2 = 16'($urandom_range(50, 2));
    fork
      wait_irq(n);
      apb(1'b1, OFS_LOW_RELOAD, {16'h0000, r2});
    join
    wait_irq(n);
    chk("new reload period", ticks(r2) - 2, n);
    // Freeze the running word; the design's checks watch that nothing moves
    @(posedge pclk);
    clk_en <= 1'b0;
    @(negedge pclk);
    chk("frozen pready", 32'h0, {31'h0, pready});
    repeat (20) @(posedge pclk);
    clk_en <= 1'b1;
    // Prescaler phase is unknown here, so the first step lands within eight clocks
    m = 16'($urandom_range(40, 2));
    apb(1'b1, OFS_LOW_COUNT, {16'h0000, m});
    wait_irq(n);
    chk("count write ticks", 32'h1, 32'(n >= 8 * m - 6 && n <= 8 * m + 1));
    give_verdict;
  end
endmodule

/* timer16_pkg.sv */
// Constants for the cascaded 16-bit down timer and its APB register map.
// Assumes a single 40 MHz clock that stands in for the crystal clock.
package timer16_pkg;

  // APB byte addresses, one aligned word each
  localparam logic [7:0] OFS_TIMER_CONTROL = 8'hc0;
  localparam logic [7:0] OFS_LOW_COUNT = 8'hc4;
  localparam logic [7:0] OFS_LOW_RELOAD = 8'hc8;
  localparam logic [7:0] OFS_HIGH_COUNT = 8'hcc;
  localparam logic [7:0] OFS_HIGH_RELOAD = 8'hd0;

  // Control register fields
  localparam int CTL_ENABLE_POS = 0;
  localparam int CTL_RELOAD_POS = 1;

  // Reset values
  localparam logic [1:0] CTL_RESET = 2'h2;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;

  // One decrement every eighth crystal clock
  localparam int TICK_DIVIDE = 8;
  localparam logic [2:0] TICK_LAST = 3'(TICK_DIVIDE - 1);

  // Count values at which the next step reaches zero
  localparam logic [15:0] COUNT_ONE = 16'h0001;

endpackage
